/* File: ccx_ctrl.sv */
// Dual-channel mode control and PCM transmit port
// Functional notes
// - Power-interrupt flag reads 1, cleared by software reset
// - Only activate command enters active mode
// - Software reset and deactivate enter standby, keep settings
// - Any reset restores basic defaults
// - Hardware reset also clears slots, edge; channel 1 to port A, channel 2 to port B
// - Software reset: basic defaults, selected channels only
// - Hardware and power-up reset: full defaults
// - Frame starts at frame sync
// - Seven-bit time slot, 128 slots
// - Three-bit clock slot offset 0 to 7
// - Byte sent MSB first
// - Fractional tail slot may carry junk
// - Selected port drives, its strobe low
// - Edge select picks falling or rising edge
// - Optional data delay in falling mode
// - Strobe follows sync by slot value
// - Command bytes MSB first, own select
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ccx_map.svh"
module ccx_ctrl
	import ccx_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic power_fail_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic pcm_clk_i,
	input wire logic frame_sync_i,
	input wire logic [7:0] sample_one_i,
	input wire logic [7:0] sample_two_i,
	output logic pcm_out_port_a_o,
	output logic pcm_out_port_a_oe_o,
	output logic pcm_out_port_b_o,
	output logic pcm_out_port_b_oe_o,
	output logic slot_strobe_a_n_o,
	output logic slot_strobe_b_n_o,
	output logic [1:0] active_o
);
	ccx_mode_type mode [2];
	ccx_tx_cfg_type cfg [2];
	ccx_pin_type pin [2];
	logic [7:0] misc [2];
	logic pwr_flag;
	logic mclk_4m;
	logic [2:0] pclk_sync;
	logic [2:0] fs_sync;
	logic pclk_rise;
	logic pclk_fall;
	logic frame_start;
	logic [1:0] sel;
	logic cmd_wr;

	// Two-stage synchronisers; third stage for clock edge detection and as the frame sync sample
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pclk_sync <= 3'h0;
			fs_sync <= 3'h0;
		end else if (clk_en_i) begin
			pclk_sync <= {pclk_sync[1:0], pcm_clk_i};
			fs_sync <= {fs_sync[1:0], frame_sync_i};
		end
	end
	assign pclk_rise = pclk_sync[1] & ~pclk_sync[2];
	assign pclk_fall = ~pclk_sync[1] & pclk_sync[2];
	// Frame sync sampled on a falling PCM clock edge, high marks frame start
	assign frame_start = pclk_fall & fs_sync[2];

	assign cmd_wr = clk_en_i && wr_i && addr_i == `CCX_REG_CMD;
	assign sel = {wdata_i[`CCX_CMD_CH2_BIT], wdata_i[`CCX_CMD_CH1_BIT]};

	// Per-channel mode and settings; commands carry channel select bits
	// because the serial port framing sits outside this block
	for (genvar c = 0; c < 2; c++) begin : g_ch
		always_ff @(posedge sys_clk_i) begin
			if (reset_i) begin
				mode[c] <= CCX_STANDBY;
				misc[c] <= `CCX_MISC_RESET;
				cfg[c] <= '{time_slot: 7'h00, clock_slot: 3'h0, edge_rise: 1'b0,
					out_delay: 1'b1, port_b: (c == 1)};
			end else if (clk_en_i) begin
				if (cmd_wr && sel[c]) begin
					case (wdata_i[7:0])
						`CCX_CMD_ACT: mode[c] <= CCX_ACTIVE;
						`CCX_CMD_DEACT: mode[c] <= CCX_STANDBY;
						`CCX_CMD_SWRST: begin
							mode[c] <= CCX_STANDBY;
							misc[c] <= `CCX_MISC_RESET;
						end
						default: mode[c] <= mode[c];
					endcase
				end
				if (wr_i && sel[c] && addr_i == `CCX_REG_TX_SLOT) begin
					cfg[c].time_slot <= wdata_i[6:0];
					cfg[c].clock_slot <= wdata_i[10:8];
				end
				if (wr_i && sel[c] && addr_i == `CCX_REG_TX_CFG) begin
					cfg[c].edge_rise <= wdata_i[`CCX_CFG_EDGE_BIT];
					cfg[c].out_delay <= wdata_i[`CCX_CFG_DELAY_BIT];
					cfg[c].port_b <= wdata_i[`CCX_CFG_PORTB_BIT];
				end
				if (wr_i && sel[c] && addr_i == `CCX_REG_MISC) begin
					misc[c] <= wdata_i[7:0];
				end
			end
		end
		// Fractional tail simply outputs the next counted bits, hence junk
		ccx_tx_chan u_tx (
			.sys_clk_i(sys_clk_i),
			.reset_i(reset_i),
			.clk_en_i(clk_en_i),
			.frame_start_i(frame_start),
			.pclk_rise_i(pclk_rise),
			.pclk_fall_i(pclk_fall),
			.active_i(mode[c] == CCX_ACTIVE),
			.cfg_i(cfg[c]),
			.sample_i(c == 0 ? sample_one_i : sample_two_i),
			.pin_o(pin[c])
		);
		assign active_o[c] = (mode[c] == CCX_ACTIVE);
	end

	// Clock-rate select is global; defaults to the faster rate
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			mclk_4m <= 1'b1;
		end else if (clk_en_i && cmd_wr && wdata_i[7:0] == `CCX_CMD_MCLK) begin
			mclk_4m <= wdata_i[12];
		end
	end

	// Power-interrupt flag: supply event wins over a same-cycle clear
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pwr_flag <= 1'b1; // Power-up counts as an interruption
		end else if (clk_en_i) begin
			if (power_fail_i) begin
				pwr_flag <= 1'b1;
			end else if (cmd_wr && sel != 2'b00 && wdata_i[7:0] == `CCX_CMD_SWRST) begin
				pwr_flag <= 1'b0;
			end
		end
	end

	// Read data one cycle after the strobe; channel picked by addr bit 3
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rdata_o <= 16'h0000;
		end else if (clk_en_i) begin
			rdata_o <= 16'h0000;
			if (rd_i) begin
				case (addr_i[2:0])
					3'h1: rdata_o <= {5'h00, cfg[addr_i[3]].clock_slot, 1'b0,
						cfg[addr_i[3]].time_slot};
					3'h2: rdata_o <= {13'h0000, cfg[addr_i[3]].port_b,
						cfg[addr_i[3]].out_delay, cfg[addr_i[3]].edge_rise};
					3'h4: rdata_o <= {13'h0000, mclk_4m, active_o};
					3'h5: rdata_o <= {8'h00, pwr_flag, 7'h00};
					3'h6: rdata_o <= {8'h00, misc[addr_i[3]]};
					default: rdata_o <= 16'h0000;
				endcase
			end
		end
	end

	// Port steering: each channel goes to its selected port
	always_comb begin
		pcm_out_port_a_o = 1'b0;
		pcm_out_port_a_oe_o = 1'b0;
		pcm_out_port_b_o = 1'b0;
		pcm_out_port_b_oe_o = 1'b0;
		slot_strobe_a_n_o = 1'b1;
		slot_strobe_b_n_o = 1'b1;
		for (int i = 0; i < 2; i++) begin
			if (pin[i].data_oe) begin
				if (cfg[i].port_b) begin
					pcm_out_port_b_o = pin[i].data;
					pcm_out_port_b_oe_o = 1'b1;
					slot_strobe_b_n_o = 1'b0;
				end else begin
					pcm_out_port_a_o = pin[i].data;
					pcm_out_port_a_oe_o = 1'b1;
					slot_strobe_a_n_o = 1'b0;
				end
			end
		end
	end

	a_act_only_cmd: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!active_o[0] && !(cmd_wr && sel[0] && wdata_i[7:0] == `CCX_CMD_ACT)
		|=> !active_o[0]) else $error("activated without command");
	a_deact_standby: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		cmd_wr && sel[1] && wdata_i[7:0] == `CCX_CMD_DEACT |=> !active_o[1])
		else $error("deactivate ignored");
	a_swrst_scope: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		cmd_wr && sel == 2'b01 && wdata_i[7:0] == `CCX_CMD_SWRST && active_o[1]
		|=> active_o[1]) else $error("reset hit wrong channel");
	a_flag_sets: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		clk_en_i && power_fail_i |=> pwr_flag) else $error("flag lost");
	a_flag_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		cmd_wr && sel != 2'b00 && wdata_i[7:0] == `CCX_CMD_SWRST && !power_fail_i
		|=> !pwr_flag) else $error("flag not cleared");
	a_reset_defaults: assert property (@(posedge sys_clk_i)
		reset_i |=> cfg[1].port_b && !cfg[0].port_b && cfg[0].out_delay && mclk_4m)
		else $error("bad reset defaults");
endmodule
`default_nettype wire

/* File: ccx_highway.sv */
// Behavioural PCM highway: bit clock, frame sync and byte capture
`timescale 1ns/1ps
`default_nettype none
module ccx_highway (
	input wire logic rise_i,
	input wire logic data_a_i,
	input wire logic oe_a_i,
	input wire logic data_b_i,
	input wire logic oe_b_i,
	input wire logic strobe_a_n_i,
	input wire logic strobe_b_n_i,
	output logic pcm_clk_o,
	output logic frame_sync_o,
	output logic got_o,
	output logic [8:0] byte_o
);
	int bit_n;
	int nrx;
	logic [7:0] sh;
	logic line_a;
	logic line_b;
	// Released lines float up to the pull-up level
	assign line_a = oe_a_i ? data_a_i : 1'b1;
	assign line_b = oe_b_i ? data_b_i : 1'b1;
	// Free-running bit clock, 64 ns period; faster than a real highway
	// allows, traded for short runs, the design only sees edges
	initial begin
		pcm_clk_o = 1'b0;
		bit_n = 0;
		nrx = 0;
		got_o = 1'b0;
		frame_sync_o = 1'b0;
		forever #32 pcm_clk_o = ~pcm_clk_o;
	end
	// Exactly 32 bit clocks a frame; sync high across bit 0
	always @(posedge pcm_clk_o) begin
		bit_n = (bit_n + 1) % 32;
		frame_sync_o = (bit_n == 0);
	end
	// Capture on the edge opposite the launch edge, so data has settled
	always @(posedge pcm_clk_o or negedge pcm_clk_o) begin
		if (pcm_clk_o != rise_i) begin
			got_o = 1'b0;
			if (strobe_a_n_i && strobe_b_n_i) begin
				nrx = 0;
			end else begin
				sh = {sh[6:0], strobe_a_n_i ? line_b : line_a};
				nrx = nrx + 1;
				if (nrx == 8) begin
					byte_o = {strobe_a_n_i, sh};
					got_o = 1'b1;
					nrx = 0;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: ccx_map.svh */
// Constants for the channel control and PCM transmit block
`ifndef CCX_MAP_SVH
`define CCX_MAP_SVH
// Register indices on the plain register port
`define CCX_ADDR_W 4
`define CCX_REG_CMD 4'h0
`define CCX_REG_TX_SLOT 4'h1
`define CCX_REG_TX_CFG 4'h2
`define CCX_REG_SAMPLE 4'h3
`define CCX_REG_STATUS 4'h4
`define CCX_REG_LI_DIR 4'h5
`define CCX_REG_MISC 4'h6
// Command codes
`define CCX_CMD_DEACT 8'h01
`define CCX_CMD_SWRST 8'h02
`define CCX_CMD_ACT 8'h05
`define CCX_CMD_MCLK 8'h06
// Field positions
`define CCX_CMD_CH1_BIT 8
`define CCX_CMD_CH2_BIT 9
`define CCX_CFG_EDGE_BIT 0
`define CCX_CFG_DELAY_BIT 1
`define CCX_CFG_PORTB_BIT 2
`define CCX_PWR_FLAG_BIT 7
// Misc register (default-state fields)
`define CCX_MISC_RESET 8'h00
`define CCX_SLOT_BITS 8
`endif

/* File: ccx_pkg.sv */
// Types for the channel control and PCM transmit block
package ccx_pkg;
	typedef enum logic {CCX_STANDBY, CCX_ACTIVE} ccx_mode_type;
	typedef struct packed {
		logic [6:0] time_slot;
		logic [2:0] clock_slot;
		logic edge_rise;
		logic out_delay;
		logic port_b;
	} ccx_tx_cfg_type;
	typedef struct packed {
		logic data;
		logic data_oe;
		logic strobe_n;
	} ccx_pin_type;
endpackage

/* File: ccx_tx_chan.sv */
// One channel's transmit slot sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ccx_map.svh"
module ccx_tx_chan
	import ccx_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic frame_start_i,
	input wire logic pclk_rise_i,
	input wire logic pclk_fall_i,
	input wire logic active_i,
	input wire ccx_tx_cfg_type cfg_i,
	input wire logic [7:0] sample_i,
	output ccx_pin_type pin_o
);
	logic [10:0] bit_count;
	logic [7:0] shift;
	logic in_slot;
	logic [10:0] slot_start;
	logic launch;
	logic dly_data;
	logic [7:0] frame_sample;

	// Slot start in PCM clocks after frame sync
	assign slot_start = {1'b0, cfg_i.time_slot, 3'h0} + {8'h00, cfg_i.clock_slot};
	// Launch edge: falling when edge-select is 0, rising otherwise
	assign launch = cfg_i.edge_rise ? pclk_rise_i : pclk_fall_i;

	// Bit counter restarts at frame sync
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			bit_count <= 11'h7FF;
		end else if (clk_en_i) begin
			if (frame_start_i) begin
				bit_count <= 11'h000;
			end else if (launch && bit_count != 11'h7FF) begin
				bit_count <= bit_count + 11'h001;
			end
		end
	end

	// Sample latched per frame so a byte never tears mid-slot
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			frame_sample <= 8'h00;
		end else if (clk_en_i && frame_start_i) begin
			frame_sample <= sample_i;
		end
	end

	// Shift out MSB first inside the slot; fractional tail just keeps counting
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			in_slot <= 1'b0;
			shift <= 8'h00;
		end else if (clk_en_i && launch) begin
			if (active_i && bit_count == slot_start) begin
				in_slot <= 1'b1;
				shift <= frame_sample;
			end else if (in_slot && bit_count == slot_start + 11'h008) begin
				in_slot <= 1'b0;
			end else begin
				shift <= {shift[6:0], 1'b0};
			end
			if (!active_i) begin
				in_slot <= 1'b0;
			end
		end else if (clk_en_i && !active_i) begin
			in_slot <= 1'b0;
		end
	end

	// Optional extra delay on data, half a PCM clock, falling-edge mode only
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			dly_data <= 1'b0;
		end else if (clk_en_i && pclk_rise_i) begin
			dly_data <= shift[7];
		end
	end

	// Pin outputs registered
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pin_o <= '{data: 1'b0, data_oe: 1'b0, strobe_n: 1'b1};
		end else if (clk_en_i) begin
			pin_o.data_oe <= in_slot;
			pin_o.strobe_n <= ~in_slot;
			pin_o.data <= (cfg_i.out_delay && !cfg_i.edge_rise) ? dly_data : shift[7];
		end
	end

	a_strobe_oe_match: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		pin_o.strobe_n == ~pin_o.data_oe) else $error("strobe and enable disagree");
	a_standby_quiet: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(!active_i && clk_en_i) [*2] |=> !pin_o.data_oe) else $error("drives in standby");
	a_frame_restart: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		clk_en_i && frame_start_i |=> bit_count == 11'h000) else $error("no frame restart");
endmodule
`default_nettype wire

/* File: codec_channel_ctrl_pcm_tx_bench.sv */
// Self-checking bench for the channel control and PCM transmit block
`timescale 1ns/1ps
`default_nettype none
module codec_channel_ctrl_pcm_tx_bench;
	logic clk, rst, pfail, wr, rd, rise, rd_seen;
	logic [3:0] addr;
	logic [15:0] wdata, rdata;
	logic [7:0] s1, s2, lfsr;
	logic pa, pa_oe, pb, pb_oe, sa_n, sb_n, pclk, fs, got;
	logic [1:0] act;
	logic en;
	logic [8:0] hbyte;
	int n_mismatch, checks, cycles;
	logic [15:0] rd_q[$];
	logic [8:0] by_q[$];
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	ccx_ctrl dut_u (.sys_clk_i(clk), .reset_i(rst), .clk_en_i(en), .power_fail_i(pfail),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.pcm_clk_i(pclk), .frame_sync_i(fs), .sample_one_i(s1), .sample_two_i(s2),
		.pcm_out_port_a_o(pa), .pcm_out_port_a_oe_o(pa_oe), .pcm_out_port_b_o(pb),
		.pcm_out_port_b_oe_o(pb_oe), .slot_strobe_a_n_o(sa_n), .slot_strobe_b_n_o(sb_n),
		.active_o(act));
	ccx_highway hw_u (.rise_i(rise), .data_a_i(pa), .oe_a_i(pa_oe), .data_b_i(pb),
		.oe_b_i(pb_oe), .strobe_a_n_i(sa_n), .strobe_b_n_i(sb_n), .pcm_clk_o(pclk),
		.frame_sync_o(fs), .got_o(got), .byte_o(hbyte));
	function automatic logic [7:0] nxt(logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(string what, logic [15:0] e, logic [15:0] g);
		checks++;
		if (e !== g) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr_reg(logic [3:0] a, logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(logic [3:0] a, logic [15:0] e);
		rd_q.push_back(e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// Wait, bounded, until every announced byte has shown up
	task automatic wait_bytes();
		for (int i = 0; i < 1200 && by_q.size() > 0; i++) @(posedge clk);
		chk("bytes left", 16'h0000, 16'(by_q.size()));
	endtask
	// Read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		if (rd_seen) chk("rdata", rd_q.pop_front(), rdata);
		rd_seen <= rd;
	end
	// A byte nobody announced compares against an impossible value
	always @(posedge got) begin
		chk("pcm byte", (by_q.size() > 0) ? {7'h00, by_q.pop_front()} : 16'hFFFF, {7'h00, hbyte});
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	// Program one channel's slot, port and edge, then carry one byte
	task automatic run_chan(int ch, int slot, int cs, logic r, logic b);
		logic [15:0] sel;
		sel = 16'(1 << (ch + 7));
		lfsr = nxt(lfsr);
		s1 <= lfsr;
		s2 <= lfsr;
		rise <= r;
		wr_reg(4'h1, sel | 16'(cs << 8) | 16'(slot));
		wr_reg(4'h2, sel | {13'h0000, b, 1'b0, r});
		repeat (600) @(posedge clk);
		by_q.push_back({b, lfsr});
		wr_reg(4'h0, sel | 16'h0005);
		wait_bytes();
		chk("active", {14'h0000, ch == 1 ? 2'b01 : 2'b10}, {14'h0000, act});
		wr_reg(4'h0, sel | 16'h0001);
		repeat (4) @(posedge clk);
		chk("standby", 16'h0000, {14'h0000, act});
		chk("idle pins", 16'h0003, {12'h000, pa_oe, pb_oe, sa_n, sb_n});
		repeat (600) @(posedge clk);
	endtask
	initial begin
		rst = 1'b1;
		{pfail, wr, rd, rise, rd_seen} = 5'h00;
		addr = 4'h0;
		wdata = 16'h0000;
		{s1, s2} = 16'h0000;
		{n_mismatch, checks, cycles} = 96'h0;
		lfsr = 8'h55;
		en = 1'b1;
		// Power-up wait shortened to the reset hold to keep runs short
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd_reg(4'h5, 16'h0080);
		rd_reg(4'hD, 16'h0080);
		rd_reg(4'h4, 16'h0004);
		rd_reg(4'h7, 16'h0000);
		wr_reg(4'h0, 16'h1106);
		wr_reg(4'h0, 16'h0102);
		rd_reg(4'h5, 16'h0000);
		rd_reg(4'hD, 16'h0000);
		repeat (2) @(posedge clk);
		chk("active", 16'h0000, {14'h0000, act});
		run_chan(1, 2, 5, 1'b0, 1'b0);
		run_chan(2, 1, 6, 1'b1, 1'b1);
		run_chan(1, 0, 1, 1'b1, 1'b1);
		// Software reset must keep slot, port and edge settings
		wr_reg(4'h6, 16'h01A5);
		wr_reg(4'h6, 16'h025A);
		wr_reg(4'h0, 16'h0102);
		rd_reg(4'h6, 16'h0000);
		rd_reg(4'hE, 16'h005A);
		rd_reg(4'h1, 16'h0100);
		rd_reg(4'h2, 16'h0005);
		by_q.push_back({1'b1, lfsr});
		wr_reg(4'h0, 16'h0105);
		wait_bytes();
		wr_reg(4'h0, 16'h0101);
		// With the clock enable low an activate must be ignored
		en <= 1'b0;
		wr_reg(4'h0, 16'h0105);
		en <= 1'b1;
		repeat (2) @(posedge clk);
		chk("frozen", 16'h0000, {14'h0000, act});
		pfail <= 1'b1;
		@(posedge clk);
		pfail <= 1'b0;
		repeat (2) @(posedge clk);
		rd_reg(4'h5, 16'h0080);
		repeat (3) @(posedge clk);
		give_verdict();
	end
endmodule
`default_nettype wire
